// file: inc/cpc_pkg.sv
// Package for the charger power path control block: map, fields, timing
package cpc_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] CPC_CTRL_OFS   = 8'h00;
  localparam logic [7:0] CPC_CURR_OFS   = 8'h04;
  localparam logic [7:0] CPC_SYS_OFS    = 8'h08;
  localparam logic [7:0] CPC_STATUS_OFS = 8'h0C;
  localparam int         CPC_ADDR_W     = 8;

  // ==========================================================
  // Control register fields
  localparam int CTL_HIZ_BIT     = 0;
  localparam int CTL_CHG_DIS_BIT = 1;
  localparam int CTL_RECYCLE_BIT = 2;
  localparam int CTL_TERM_EN_BIT = 3;
  localparam int CTL_KEEP_BIT    = 4;
  localparam int CTL_SCALE_BIT   = 5;
  localparam logic [5:0] CTL_RESET = 6'h0A;

  // ==========================================================
  // Current register fields
  localparam int CUR_TERM_LSB = 0;
  localparam int CUR_FAST_LSB = 8;
  localparam int CUR_ILIM_LSB = 16;
  localparam logic [3:0] TERM_RESET = 4'h2;
  localparam logic [5:0] FAST_RESET = 6'h10;
  localparam logic [7:0] ILIM_RESET = 8'h40;

  // ==========================================================
  // System register fields
  localparam int SYS_VTGT_LSB = 0;
  localparam int SYS_WDP_LSB  = 8;
  localparam int SYS_KICK_BIT = 16;
  localparam logic [3:0] VTGT_RESET = 4'h7;
  localparam logic [1:0] WDP_OFF    = 2'h0;
  localparam logic [1:0] WDP_FORCED = 2'h1;
  localparam logic [1:0] WDP_MID    = 2'h2;
  localparam logic [1:0] WDP_LONG   = 2'h3;
  localparam logic [1:0] WDP_RESET  = 2'h3;

  // ==========================================================
  // Status register fields
  localparam int STS_STATE_LSB = 0;
  localparam int STS_DONE_BIT  = 4;
  localparam int STS_FAULT_BIT = 5;
  localparam int STS_INPUT_BIT = 6;
  localparam int STS_SUPP_BIT  = 7;
  localparam int STS_OVP_BIT   = 8;
  localparam int STS_WDF_BIT   = 9;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_IN_NS      = 1000000;
  localparam int CYC_PER_MS    = MS_IN_NS / CLK_PERIOD_NS;
  localparam int WDT_LONG_S    = 160;
  localparam int MS_PER_S      = 1000;
  localparam int MS_CNT_W      = 20;

  // ==========================================================
  // AHB-Lite encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] HTRANS_SEQ    = 2'h3;

  // ==========================================================
  // Charge sequencer states
  typedef enum logic [2:0] {
    CPC_IDLE  = 3'b000,
    CPC_PRE   = 3'b001,
    CPC_CC    = 3'b010,
    CPC_CV    = 3'b011,
    CPC_DONE  = 3'b100,
    CPC_FAULT = 3'b101
  } cpc_state_e;

endpackage : cpc_pkg

// file: rtl/cpc_top.sv
// Charger power path control: input qualification, power path, charge sequencer
//
// The AHB-Lite interface to the registers and the address map were decided locally.
`timescale 1ns/100ps
module cpc_top
  import cpc_pkg::*;
#(
  parameter int CYC_MS       = CYC_PER_MS,
  parameter int QUALIFY_MS   = 32,
  parameter int PULSE_QUAL_MS = 16,
  parameter int SUPPRESS_MS  = 64,
  parameter int PULSE_W_MS   = 1,
  parameter int TERM_DG_MS   = 16,
  parameter int RECYCLE_MS   = 400,
  parameter int WDT_FORCED_MS = 40000,
  parameter int WDT_MID_MS   = 80000,
  parameter int WDT_LONG_MS  = WDT_LONG_S * MS_PER_S
)
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // AHB-Lite slave
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic [31:0]                hrdata,
  output logic                       hresp,
  // Analog comparator inputs
  input  wire logic                  in_above_uvlo,
  input  wire logic                  in_below_ovlo,
  input  wire logic                  bat_below_pre,
  input  wire logic                  bat_near_reg,
  input  wire logic                  chg_below_term,
  input  wire logic                  bat_overvoltage,
  input  wire logic                  in_current_at_limit,
  input  wire logic                  in_voltage_at_floor,
  input  wire logic                  sys_below_target_margin,
  input  wire logic                  sys_below_input_margin,
  input  wire logic                  sys_below_bat_low,
  input  wire logic                  sys_above_bat_high,
  input  wire logic                  ntc_fault,
  input  wire logic                  safety_timer_fault,
  input  wire logic                  recharge_request,
  // Host interrupt
  output logic                       host_interrupt_n,
  // Power path controls
  output logic                       bypass_on,
  output logic                       reverse_block_transistor,
  output logic                       switch_charge_on,
  output logic                       switch_full_on,
  output logic                       switch_ideal_diode,
  output logic                       bypass_regulate,
  output logic                       discharge_path_on,
  output logic                       sys_recycle,
  // Charge regulation controls
  output logic                       charge_current_on,
  output logic [5:0]                 charge_current_code,
  output logic                       charge_current_scale,
  output logic                       charge_hold_voltage,
  output logic                       charge_reduce,
  output logic [7:0]                 input_current_limit,
  output logic [3:0]                 sys_voltage_target,
  output logic                       charge_done,
  output logic                       charge_fault
);

  localparam int NSYNC = 15;

  // ==========================================================
  // Input synchronisers
  logic [NSYNC-1:0] sync1_q;
  logic [NSYNC-1:0] sync2_q;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= {in_above_uvlo, in_below_ovlo, bat_below_pre, bat_near_reg, chg_below_term,
                  bat_overvoltage, in_current_at_limit, in_voltage_at_floor, sys_below_target_margin,
                  sys_below_input_margin, sys_below_bat_low, sys_above_bat_high, ntc_fault,
                  safety_timer_fault, recharge_request};
      sync2_q <= sync1_q;
    end

  logic s_uv, s_ov, s_pre, s_near, s_term, s_ovp, s_ilim, s_vlim;
  logic s_sysm, s_inm, s_low, s_high, s_ntc, s_tmr, s_rech;
  assign {s_uv, s_ov, s_pre, s_near, s_term, s_ovp, s_ilim, s_vlim,
          s_sysm, s_inm, s_low, s_high, s_ntc, s_tmr, s_rech} = sync2_q;

  // ==========================================================
  // Millisecond tick
  logic [15:0] pre_q;
  logic        tick;
  assign tick = (pre_q == 16'(CYC_MS - 1));

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      pre_q <= '0;
    else
      pre_q <= tick ? '0 : pre_q + 16'h0001;

  function automatic logic [MS_CNT_W-1:0] wd_limit(input logic [1:0] p);
    unique case (p)
      WDP_FORCED: wd_limit = MS_CNT_W'(WDT_FORCED_MS);
      WDP_MID:    wd_limit = MS_CNT_W'(WDT_MID_MS);
      WDP_LONG:   wd_limit = MS_CNT_W'(WDT_LONG_MS);
      WDP_OFF:    wd_limit = '0;
    endcase
  endfunction : wd_limit

  // ==========================================================
  // AHB-Lite slave, zero wait states
  logic        wr_pend_q;
  logic [7:0]  wr_addr_q;
  logic        addr_ok;
  logic        wr_now;
  assign addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
  assign wr_now  = wr_pend_q;

  logic [5:0]  ctrl_q;
  logic [3:0]  term_cur_q;
  logic [5:0]  fast_cur_q;
  logic [7:0]  ilim_q;
  logic [3:0]  vtgt_q;
  logic [1:0]  wdp_q;
  logic        wd_forced_q;
  logic        recycle_req;
  logic        wd_kick;
  cpc_state_e  state_q;
  logic        input_good_q;
  logic        supp_q;
  logic        wd_fired_q;
  logic [31:0] status;

  assign recycle_req = wr_now && wr_addr_q == CPC_CTRL_OFS && hwdata[CTL_RECYCLE_BIT];
  assign wd_kick     = wr_now && wr_addr_q == CPC_SYS_OFS && hwdata[SYS_KICK_BIT];

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_pend_q <= addr_ok && hwrite;
      if (addr_ok)
        wr_addr_q <= haddr[CPC_ADDR_W-1:0];
    end

  always_comb
  begin
    status = '0;
    status[STS_STATE_LSB +: 3] = state_q;
    status[STS_DONE_BIT]       = charge_done;
    status[STS_FAULT_BIT]      = charge_fault;
    status[STS_INPUT_BIT]      = input_good_q;
    status[STS_SUPP_BIT]       = supp_q;
    status[STS_OVP_BIT]        = s_ovp;
    status[STS_WDF_BIT]        = wd_forced_q;
  end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      hrdata <= '0;
    else if (addr_ok && !hwrite)
    begin
      unique case (haddr[CPC_ADDR_W-1:0])
        CPC_CTRL_OFS:   hrdata <= {26'h0, ctrl_q};
        CPC_CURR_OFS:   hrdata <= {8'h0, ilim_q, 2'h0, fast_cur_q, 4'h0, term_cur_q};
        CPC_SYS_OFS:    hrdata <= {22'h0, (wd_forced_q ? WDP_FORCED : wdp_q), 4'h0, vtgt_q};
        CPC_STATUS_OFS: hrdata <= status;
        default:        hrdata <= '0;
      endcase
    end

  // ==========================================================
  // Host registers
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      ctrl_q     <= CTL_RESET;
      term_cur_q <= TERM_RESET;
      fast_cur_q <= FAST_RESET;
      ilim_q     <= ILIM_RESET;
      vtgt_q     <= VTGT_RESET;
      wdp_q      <= WDP_RESET;
    end
    else if (wr_now)
    begin
      unique case (wr_addr_q)
        CPC_CTRL_OFS:
        begin
          ctrl_q <= hwdata[5:0];
          ctrl_q[CTL_RECYCLE_BIT] <= 1'b0;
        end
        CPC_CURR_OFS:
        begin
          term_cur_q <= hwdata[CUR_TERM_LSB +: 4];
          fast_cur_q <= hwdata[CUR_FAST_LSB +: 6];
          ilim_q     <= hwdata[CUR_ILIM_LSB +: 8];
        end
        CPC_SYS_OFS:
        begin
          vtgt_q <= hwdata[SYS_VTGT_LSB +: 4];
          wdp_q  <= hwdata[SYS_WDP_LSB +: 2];
        end
        default:
          ;
      endcase
    end

  // ==========================================================
  // Input qualification
  logic                in_ok;
  logic [MS_CNT_W-1:0] qual_q;
  logic                input_good_d;
  assign in_ok = s_uv && s_ov;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      qual_q       <= '0;
      input_good_q <= 1'b0;
    end
    else if (!in_ok)
    begin
      qual_q       <= '0;
      input_good_q <= 1'b0;
    end
    else if (!input_good_q && tick)
    begin
      qual_q       <= qual_q + 1'b1;
      input_good_q <= (qual_q >= MS_CNT_W'(QUALIFY_MS));
    end

  logic in_prev_q;
  logic in_rise;
  logic in_change;
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      in_prev_q <= 1'b0;
    else
      in_prev_q <= input_good_q;
  assign in_rise   = input_good_q && !in_prev_q;
  assign in_change = input_good_q != in_prev_q;

  // ==========================================================
  // Interrupt pulse
  logic [MS_CNT_W-1:0] pq_q;
  logic                pend_q;
  logic [MS_CNT_W-1:0] sup_q;
  logic [MS_CNT_W-1:0] pw_q;
  logic                pulse_start;
  assign pulse_start = pend_q && tick && pq_q >= MS_CNT_W'(PULSE_QUAL_MS);

  // persisting changes pulse, repeated changes restart, window blocks
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pend_q <= 1'b0;
      pq_q   <= '0;
      sup_q  <= '0;
    end
    else
    begin
      if (in_change && sup_q == '0)
      begin
        pend_q <= 1'b1;
        pq_q   <= '0;
      end
      else if (pulse_start)
        pend_q <= 1'b0;
      else if (pend_q && tick)
        pq_q <= pq_q + 1'b1;
      if (pulse_start)
        sup_q <= MS_CNT_W'(SUPPRESS_MS);
      else if (tick && sup_q != '0)
        sup_q <= sup_q - 1'b1;
    end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      pw_q             <= '0;
      host_interrupt_n <= 1'b1;
    end
    else
    begin
      if (pulse_start)
        pw_q <= MS_CNT_W'(PULSE_W_MS);
      else if (tick && pw_q != '0)
        pw_q <= pw_q - 1'b1;
      host_interrupt_n <= !(pulse_start || pw_q != '0);
    end

  // ==========================================================
  // Watchdog and power recycle
  logic [MS_CNT_W-1:0] wd_q;
  logic [MS_CNT_W-1:0] rc_q;
  logic [1:0]          wdp_eff;
  logic                wd_timeout;
  assign wdp_eff    = wd_forced_q ? WDP_FORCED : wdp_q;
  assign wd_timeout = wdp_eff != WDP_OFF && tick && wd_q >= wd_limit(wdp_eff);

  // force 01 on detect and pulse, restore on any write
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      wd_forced_q <= 1'b0;
    else if (in_rise || pulse_start)
      wd_forced_q <= 1'b1;
    else if (wr_now)
      wd_forced_q <= 1'b0;

  // timeout, unanswered forced watchdog, or recycle bit
  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      wd_q       <= '0;
      rc_q       <= '0;
      wd_fired_q <= 1'b0;
    end
    else
    begin
      if (wd_kick || wd_timeout || in_rise || pulse_start || wdp_eff == WDP_OFF)
        wd_q <= '0;
      else if (tick)
        wd_q <= wd_q + 1'b1;
      wd_fired_q <= wd_timeout;
      if (wd_timeout || recycle_req)
        rc_q <= MS_CNT_W'(RECYCLE_MS);
      else if (tick && rc_q != '0)
        rc_q <= rc_q - 1'b1;
    end

  // ==========================================================
  // Charge sequencer
  logic                rech_prev_q;
  logic                dis_prev_q;
  logic                start_evt;
  logic                start_ok;
  logic [MS_CNT_W-1:0] tdg_q;
  logic                term_hit;
  logic                recycling;
  cpc_state_e          state_d;
  assign recycling = rc_q != '0;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      rech_prev_q <= 1'b0;
      dis_prev_q  <= 1'b1;
    end
    else
    begin
      rech_prev_q <= s_rech;
      dis_prev_q  <= ctrl_q[CTL_CHG_DIS_BIT];
    end

  // start events gated by faults and forced-off switch
  assign start_evt = in_rise || (dis_prev_q && !ctrl_q[CTL_CHG_DIS_BIT]) || (s_rech && !rech_prev_q);
  assign start_ok  = !s_ntc && !s_tmr && !s_ovp && !ctrl_q[CTL_CHG_DIS_BIT] && !recycling;

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      tdg_q <= '0;
    else if (state_q != CPC_CV || !s_term)
      tdg_q <= '0;
    else if (tick && !term_hit)
      tdg_q <= tdg_q + 1'b1;
  assign term_hit = tdg_q > MS_CNT_W'(TERM_DG_MS);

  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      CPC_IDLE, CPC_DONE:
        if (start_evt && start_ok)
          state_d = s_pre ? CPC_PRE : (s_near ? CPC_CV : CPC_CC);
      CPC_PRE:
        if (!s_pre)
          state_d = CPC_CC;
      CPC_CC:
        if (s_near)
          state_d = CPC_CV;
      CPC_CV:
        if (ctrl_q[CTL_TERM_EN_BIT] && term_hit)
          state_d = CPC_DONE;
      CPC_FAULT:
        if (!s_ovp)
          state_d = CPC_IDLE;
      default:
        state_d = CPC_IDLE;
    endcase
    if (s_ovp && state_q != CPC_IDLE)
      state_d = CPC_FAULT;
    // loss of input or abort returns to idle
    if (!input_good_q || recycling || ctrl_q[CTL_CHG_DIS_BIT] || s_ntc || s_tmr)
      state_d = CPC_IDLE;
  end

  always_ff @(posedge mclk or posedge rst)
    if (rst)
      state_q <= CPC_IDLE;
    else
      state_q <= state_d;

  // ==========================================================
  // Supplement mode
  // enter on low margin, leave on high margin
  always_ff @(posedge mclk or posedge rst)
    if (rst)
      supp_q <= 1'b0;
    else if (!input_good_q || s_high)
      supp_q <= 1'b0;
    else if (s_low)
      supp_q <= 1'b1;

  // ==========================================================
  // Registered outputs
  logic charging;
  assign charging = state_q == CPC_PRE || state_q == CPC_CC || state_q == CPC_CV ||
                    (state_q == CPC_DONE && ctrl_q[CTL_KEEP_BIT]);

  always_ff @(posedge mclk or posedge rst)
    if (rst)
    begin
      bypass_on                <= 1'b0;
      reverse_block_transistor <= 1'b0;
      switch_charge_on         <= 1'b0;
      switch_full_on           <= 1'b0;
      switch_ideal_diode       <= 1'b0;
      bypass_regulate          <= 1'b0;
      discharge_path_on        <= 1'b0;
      sys_recycle              <= 1'b0;
      charge_current_on        <= 1'b0;
      charge_current_code      <= '0;
      charge_current_scale     <= 1'b0;
      charge_hold_voltage      <= 1'b0;
      charge_reduce            <= 1'b0;
      input_current_limit      <= ILIM_RESET;
      sys_voltage_target       <= VTGT_RESET;
      charge_done              <= 1'b0;
      charge_fault             <= 1'b0;
    end
    else
    begin
      // bypass opens on bad input, recycle or high impedance
      bypass_on                <= input_good_q && !recycling && !ctrl_q[CTL_HIZ_BIT];
      reverse_block_transistor <= input_good_q && !recycling;
      // charge disable blocks only the charge direction
      switch_charge_on         <= charging && !ctrl_q[CTL_CHG_DIS_BIT];
      // discharge mode holds the switch fully on
      switch_full_on           <= !input_good_q && !recycling;
      switch_ideal_diode       <= supp_q && !recycling;
      // either input limit regulates the bypass
      bypass_regulate          <= input_good_q && (s_ilim || s_vlim);
      input_current_limit      <= ilim_q;
      discharge_path_on        <= s_ovp;
      sys_recycle              <= recycling;
      // current stops at done unless tapering kept
      charge_current_on        <= charging;
      // pre-charge current, fast current with scale
      charge_current_code      <= (state_q == CPC_PRE) ? {2'h0, term_cur_q} : fast_cur_q;
      charge_current_scale     <= ctrl_q[CTL_SCALE_BIT];
      charge_hold_voltage      <= state_q == CPC_CV || state_q == CPC_DONE;
      // below both margins cuts charge current
      charge_reduce            <= s_sysm && s_inm;
      sys_voltage_target       <= vtgt_q;
      charge_done              <= state_q == CPC_DONE;
      charge_fault             <= state_q == CPC_FAULT;
    end

endmodule : cpc_top

// file: tb/cpc_env.sv
// Supply and battery comparator model facing the charger block
`timescale 1ns/100ps
module cpc_env (
  // Knobs
  input  wire logic       vin_ok,
  input  wire logic [1:0] phase,
  input  wire logic       ovp,
  // Comparator levels
  output logic            in_above_uvlo,
  output logic            in_below_ovlo,
  output logic            bat_below_pre,
  output logic            bat_near_reg,
  output logic            chg_below_term,
  output logic            bat_overvoltage
);
  // ==========================================
  // Levels
  // both limits move together
  assign in_above_uvlo   = vin_ok;
  assign in_below_ovlo   = vin_ok;
  assign bat_below_pre   = phase == 2'h0;
  assign bat_near_reg    = phase[1];
  assign chg_below_term  = phase == 2'h3;
  assign bat_overvoltage = ovp;
endmodule : cpc_env

// file: tb/cpc_checker.sv
// Port assertions for the charger block
`timescale 1ns/100ps
module cpc_checker (
  // Clock, reset and inputs
  input wire logic       mclk,
  input wire logic       rst,
  input wire logic       in_above_uvlo,
  input wire logic       bat_overvoltage,
  input wire logic       bat_below_pre,
  input wire logic       bat_near_reg,
  input wire logic       sys_below_target_margin,
  input wire logic       sys_below_input_margin,
  // Outputs
  input wire logic       host_interrupt_n,
  input wire logic       bypass_on,
  input wire logic       reverse_block_transistor,
  input wire logic       switch_full_on,
  input wire logic       switch_charge_on,
  input wire logic       sys_recycle,
  input wire logic       discharge_path_on,
  input wire logic       charge_current_on,
  input wire logic [5:0] charge_current_code,
  input wire logic       charge_reduce
);
  // ==========================================
  // Properties
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  property p_loss; $fell(in_above_uvlo) |-> ##[1:6] (!bypass_on && !reverse_block_transistor); endproperty
  a_loss: assert property (p_loss) else $error("path left closed on input loss");
  property p_disch; (!in_above_uvlo && !sys_recycle)[*8] |-> switch_full_on; endproperty
  a_disch: assert property (p_disch) else $error("switch not full on without input");
  property p_ovp; bat_overvoltage[*5] |-> discharge_path_on && !charge_current_on && !switch_charge_on; endproperty
  a_ovp: assert property (p_ovp) else $error("over-voltage not handled");
  property p_pre; (bat_below_pre && !bat_near_reg)[*5] ##0 charge_current_on |-> charge_current_code[5:4] == 2'h0;
  endproperty
  a_pre: assert property (p_pre) else $error("pre-charge code too large");
  property p_red; (sys_below_target_margin && sys_below_input_margin)[*5] |-> charge_reduce; endproperty
  a_red: assert property (p_red) else $error("charge not reduced");
  property p_nored; (!sys_below_target_margin)[*5] |-> !charge_reduce; endproperty
  a_nored: assert property (p_nored) else $error("charge reduced without cause");
  property p_irq; $fell(host_interrupt_n) |=> !host_interrupt_n[*8]; endproperty
  a_irq: assert property (p_irq) else $error("interrupt pulse too short");
  property p_sup; $rose(host_interrupt_n) |=> host_interrupt_n[*8]; endproperty
  a_sup: assert property (p_sup) else $error("interrupt inside window");
  property p_rcy; $rose(sys_recycle) |=> sys_recycle[*8]; endproperty
  a_rcy: assert property (p_rcy) else $error("recycle too short");
  property p_rcyoff; sys_recycle[*3] |-> !bypass_on && !switch_charge_on; endproperty
  a_rcyoff: assert property (p_rcyoff) else $error("power kept during recycle");
  c_irq: cover property ($fell(host_interrupt_n));
  c_rcy: cover property ($rose(sys_recycle));
  c_red: cover property (charge_reduce);
endmodule : cpc_checker
bind cpc_top cpc_checker u_chk (.mclk, .rst, .in_above_uvlo, .bat_overvoltage, .bat_below_pre, .bat_near_reg,
  .sys_below_target_margin, .sys_below_input_margin, .host_interrupt_n, .bypass_on, .reverse_block_transistor,
  .switch_full_on, .switch_charge_on, .sys_recycle, .discharge_path_on, .charge_current_on, .charge_current_code,
  .charge_reduce);

// file: tb/tb_top.sv
// Self-checking bench for the charger block
`timescale 1ns/100ps
module tb_top;
  import cpc_pkg::*;
  // ==========================================
  // Signals
  logic        mclk, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, vin_ok = 1'b0, ovp = 1'b0, lim = 1'b0, mrg = 1'b0;
  logic        ntc = 1'b0, tmr = 1'b0, rech = 1'b0, low = 1'b0, hi = 1'b0;
  logic [1:0]  htrans = 2'h0, phase = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  int          bad_count = 0, compares = 0, irq_cnt = 0, cyc = 0;
  wire logic        hready, hreadyout, hresp, in_above_uvlo, in_below_ovlo, bat_below_pre, bat_near_reg;
  wire logic        chg_below_term, bat_overvoltage, host_interrupt_n, bypass_on, reverse_block_transistor;
  wire logic        switch_charge_on, switch_full_on, switch_ideal_diode, bypass_regulate, discharge_path_on;
  wire logic        sys_recycle, charge_current_on, charge_current_scale, charge_hold_voltage, charge_reduce;
  wire logic        charge_done, charge_fault;
  wire logic [31:0] hrdata;
  wire logic [5:0]  charge_current_code;
  wire logic [7:0]  input_current_limit;
  wire logic [3:0]  sys_voltage_target;
  assign hready = hreadyout;
  cpc_top #(.CYC_MS(10), .QUALIFY_MS(4), .PULSE_QUAL_MS(2), .SUPPRESS_MS(8), .PULSE_W_MS(1), .TERM_DG_MS(2),
    .RECYCLE_MS(4), .WDT_FORCED_MS(20), .WDT_MID_MS(40), .WDT_LONG_MS(80)) u_dut (.mclk, .rst, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout, .hrdata, .hresp, .in_above_uvlo, .in_below_ovlo,
    .bat_below_pre, .bat_near_reg, .chg_below_term, .bat_overvoltage, .in_current_at_limit(lim),
    .in_voltage_at_floor(lim), .sys_below_target_margin(mrg), .sys_below_input_margin(mrg),
    .sys_below_bat_low(low), .sys_above_bat_high(hi), .ntc_fault(ntc), .safety_timer_fault(tmr),
    .recharge_request(rech), .host_interrupt_n, .bypass_on, .reverse_block_transistor, .switch_charge_on,
    .switch_full_on, .switch_ideal_diode, .bypass_regulate, .discharge_path_on, .sys_recycle, .charge_current_on,
    .charge_current_code, .charge_current_scale, .charge_hold_voltage, .charge_reduce, .input_current_limit,
    .sys_voltage_target, .charge_done, .charge_fault);
  cpc_env u_env (.vin_ok, .phase, .ovp, .in_above_uvlo, .in_below_ovlo, .bat_below_pre, .bat_near_reg,
    .chg_below_term, .bat_overvoltage);
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  always @(negedge host_interrupt_n) irq_cnt++;
  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      bad_count++;
      summarize();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      bad_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge mclk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    do @(posedge mclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    int n;
    n = 0;
    bus(1'b0, a, 32'h0);
    while ((rd & m) !== e && n < 200)
    begin
      bus(1'b0, a, 32'h0);
      n++;
    end
    chk(rd & m, e);
  endtask : poll
  task automatic summarize();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  initial
  begin
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    poll(CPC_CTRL_OFS, 32'hFFFFFFFF, 32'h0000000A);
    poll(CPC_CURR_OFS, 32'hFFFFFFFF, 32'h00401002);
    poll(CPC_SYS_OFS, 32'hFFFFFFFF, 32'h00000307);
    poll(8'h10, 32'hFFFFFFFF, 32'h0);
    $display("test reset done");
    vin_ok <= 1'b1;
    repeat (20) @(posedge mclk);
    bus(1'b0, CPC_STATUS_OFS, 32'h0);
    chk(rd & 32'h40, 32'h0);
    poll(CPC_STATUS_OFS, 32'h40, 32'h40);
    poll(CPC_SYS_OFS, 32'h300, 32'h100);
    repeat (60) @(posedge mclk);
    chk(irq_cnt, 32'h1);
    bus(1'b1, CPC_CTRL_OFS, 32'h08);
    poll(CPC_SYS_OFS, 32'h300, 32'h300);
    $display("test input done");
    poll(CPC_STATUS_OFS, 32'h7, 32'h1);
    chk(charge_current_code, 32'h2);
    bus(1'b1, CPC_SYS_OFS, 32'h0000000B);
    repeat (2) @(posedge mclk);
    chk(sys_voltage_target, 32'hB);
    phase <= 2'h1;
    poll(CPC_STATUS_OFS, 32'h7, 32'h2);
    chk(charge_current_code, 32'h10);
    bus(1'b1, CPC_CTRL_OFS, 32'h28);
    repeat (2) @(posedge mclk);
    chk(charge_current_scale, 32'h1);
    phase <= 2'h2;
    poll(CPC_STATUS_OFS, 32'h7, 32'h3);
    chk(charge_hold_voltage, 32'h1);
    phase <= 2'h3;
    poll(CPC_STATUS_OFS, 32'h7, 32'h4);
    chk({charge_done, charge_current_on}, 32'h2);
    $display("test charge done");
    ovp <= 1'b1;
    poll(CPC_STATUS_OFS, 32'h7, 32'h5);
    chk(charge_fault, 32'h1);
    ovp <= 1'b0;
    lim <= 1'b1;
    mrg <= 1'b1;
    low <= 1'b1;
    repeat (6) @(posedge mclk);
    chk({charge_reduce, bypass_regulate, bypass_on, switch_ideal_diode, input_current_limit}, 32'hF40);
    lim <= 1'b0;
    mrg <= 1'b0;
    hi <= 1'b1;
    rech <= 1'b1;
    bus(1'b1, CPC_CTRL_OFS, 32'h29);
    repeat (3) @(posedge mclk);
    chk({bypass_on, switch_ideal_diode, hresp}, 32'h0);
    poll(CPC_STATUS_OFS, 32'h7, 32'h4);
    ntc <= 1'b1;
    tmr <= 1'b1;
    poll(CPC_STATUS_OFS, 32'h7, 32'h0);
    bus(1'b1, CPC_CTRL_OFS, 32'h0C);
    repeat (2) @(posedge mclk);
    chk(sys_recycle, 32'h1);
    repeat (60) @(posedge mclk);
    vin_ok <= 1'b0;
    repeat (10) @(posedge mclk);
    chk({bypass_on, reverse_block_transistor, switch_full_on}, 32'h1);
    poll(CPC_STATUS_OFS, 32'h7, 32'h0);
    $display("test protection done");
    summarize();
  end
endmodule : tb_top
